/* File: hw/asgen_uart.sv */
// Async serial port with programmable baud generator and sync-mode pins
// Overview of operation
// RL1: Writing transmit register starts framed transmission
// RL2: Empty shift register raises transmit done
// RL3: Software never rewrites mode during transmission
// RL4: Receive enable bit six enables sampling
// RL5: Low input, half bit, recheck start bit
// RL6: Frame ends after data, parity, stop
// RL7: Frame end loads buffer, raises done
// RL8: Errored frame loaded; done unless suppressed
// RL9: Clearing receive enable aborts without effects
// RL10: Late receive disable gives three outcomes
// RL11: Software reads buffer after every frame
// RL12: Error request precedes receive done request
// RL13: Flag parity, framing and overrun errors
// RL14: Status clears on buffer read, next frame
// RL15: Software reads status before the buffer
// RL16: Software reloads ones after transmit abort
// RL17: Sync mode uses clock, out, in; the code holds clock high, and out echoes in while sync bit 7 is set and stays high otherwise
// RL18: Sync register resets zero, reserved zero
// RL19: Sync mode needs async mode zero
// RL20: Divider nibble divides by sixteen plus k; the code bypasses the divider for nibble f
// RL21: Prescale nibble selects counter source clock
// RL22: Software never writes baud during transfer
// RL23: Frame format set by mode register
// RL24: Seven-bit characters drop and zero bit seven
// RL25: Baud is source over power, 16+k
// RL26: Idle transmit line stays high
`timescale 1ns/10ps
module asgen_uart
	import asgen_pkg::*;
#(
	parameter int FIFO_DEPTH = ASGEN_FIFO_DEPTH
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic osc_mode_bit,
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic tx_ready,
	input wire logic rxd,
	output logic txd,
	output logic sync_serial_clk,
	output logic sync_serial_out,
	input wire logic sync_serial_in,
	output logic tx_done_irq,
	output logic tx_done_flag,
	output logic rx_done_irq,
	output logic rx_error_irq
);

	// ****************************************
	// Helper functions
	// ****************************************

	// Mask of prescaler bits that must be all ones for a source tick
	function automatic logic [9:0] pre_mask(input logic [3:0] code);
		int shift;
		logic [9:0] m;
		shift = ASGEN_PRE_SLOW_SHIFT;
		if (code >= ASGEN_PRE_BASE && code <= ASGEN_PRE_TOP) begin
			shift = int'(code - ASGEN_PRE_BASE);
		end
		for (int i = 0; i < 10; i++) begin
			m[i] = (i < shift);
		end
		return m;
	endfunction

	// Last count of the 5-bit counter for one half bit
	function automatic logic [4:0] half_last(input logic [3:0] div);
		if (div == ASGEN_DIV_BYPASS) begin
			return 5'h00;
		end
		return ASGEN_DIV_BASE + {1'b0, div} - 5'h01;
	endfunction

	// Parity bit for the chosen scheme; none and zero both give 0
	function automatic logic par_bit(input logic [1:0] sel, input logic [7:0] data);
		if (sel == ASGEN_PAR_EVEN) begin
			return ^data;
		end else if (sel == ASGEN_PAR_ODD) begin
			return ~^data;
		end
		return 1'b0;
	endfunction

	// ****************************************
	// Reset release and input synchronisers
	// ****************************************
	logic [1:0] rst_sync;      // Reset release pipeline
	logic rst_n;               // Synchronised reset
	logic [2:0] rxd_sync;      // Receive pin stages
	logic rx_level;            // Accepted receive level
	logic [2:0] si_sync;       // Sync-mode input stages
	logic si_level;            // Accepted sync-mode input level

	// Release reset only after two clean edges
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// Pin levels count only once stages two and three agree
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rxd_sync <= 3'h7;
			si_sync <= 3'h7;
			rx_level <= 1'b1;
			si_level <= 1'b1;
		end else begin
			rxd_sync <= {rxd_sync[1:0], rxd};
			si_sync <= {si_sync[1:0], sync_serial_in};
			if (rxd_sync[1] == rxd_sync[2]) begin
				rx_level <= rxd_sync[2];
			end
			if (si_sync[1] == si_sync[2]) begin
				si_level <= si_sync[2];
			end
		end
	end

	// ****************************************
	// Register file
	// ****************************************
	asgen_mode_t mode;         // Async mode register
	asgen_baud_t baud;         // Baud control register
	logic [7:0] sync_mode;     // Synchronous mode register
	asgen_status_t status;     // Receive status register
	logic [7:0] rx_buffer_reg; // Last received character
	logic wr_mode;
	logic wr_data;
	logic rd_data;

	assign wr_mode = reg_wr && (reg_addr == ASGEN_ADDR_MODE);
	assign wr_data = reg_wr && (reg_addr == ASGEN_ADDR_DATA);
	assign rd_data = reg_rd && (reg_addr == ASGEN_ADDR_DATA);

	// Control register writes
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode <= ASGEN_MODE_RST;
			baud <= ASGEN_BAUD_RST;
			sync_mode <= ASGEN_SYNC_RST;
		end else if (wr_mode) begin
			mode <= reg_wdata;
		end else if (reg_wr && reg_addr == ASGEN_ADDR_BAUD) begin
			baud <= reg_wdata;
		end else if (reg_wr && reg_addr == ASGEN_ADDR_SYNC) begin
			// RL18: reserved bits forced zero
			sync_mode <= reg_wdata & ASGEN_SYNC_WMASK;
		end
	end

	// Read data registered one cycle after the strobe
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (reg_addr == ASGEN_ADDR_MODE) begin
				reg_rdata <= mode;
			end else if (reg_addr == ASGEN_ADDR_STATUS) begin
				reg_rdata <= status;
			end else if (reg_addr == ASGEN_ADDR_SYNC) begin
				reg_rdata <= sync_mode;
			end else if (reg_addr == ASGEN_ADDR_BAUD) begin
				reg_rdata <= baud;
			end else if (reg_addr == ASGEN_ADDR_DATA) begin
				reg_rdata <= rx_buffer_reg;
			end else begin
				// Unmapped addresses read as zero
				reg_rdata <= 8'h00;
			end
		end
	end

	// ****************************************
	// Baud rate generator source
	// ****************************************
	logic fx_half;             // Toggle giving fx/2 when osc mode is low
	logic fxx_en;              // One system-clock tick
	logic [9:0] pre_cnt;       // Prescaler
	logic fsck_tick;           // Source tick of the 5-bit counters
	logic [4:0] half_lim;      // Half-bit terminal count

	assign fxx_en = osc_mode_bit || fx_half;
	// RL21: source select by prescale nibble
	assign fsck_tick = fxx_en && ((pre_cnt & pre_mask(baud.prescale_select))
		== pre_mask(baud.prescale_select));
	// RL20: divide by sixteen plus k, nibble f bypasses the divider
	assign half_lim = half_last(baud.divider_select);

	// Free-running prescaler; shared so tx and rx see one time base
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fx_half <= 1'b0;
			pre_cnt <= 10'h000;
		end else begin
			fx_half <= ~fx_half;
			if (fxx_en) begin
				pre_cnt <= pre_cnt + 10'h001;
			end
		end
	end

	// ****************************************
	// Transmit queue and transmitter
	// ****************************************
	asgen_tx_state_t tx_state;
	logic [7:0] q_data;        // Head of queue
	logic q_valid;
	logic q_take;              // Transmitter takes the head
	logic [7:0] tx_shift_reg;  // Bits still to send
	logic [2:0] tx_bits;       // Data bits sent
	logic tx_par;              // Parity to send
	logic tx_stop2;            // Second stop bit pending
	logic [4:0] tx_cnt;        // 5-bit bit timer
	logic tx_phase;            // Second half of a bit
	logic tx_bit_end;          // Full bit elapsed

	// RL1: a write queues the character
	asgen_fifo #(.WIDTH(ASGEN_DATA_W), .DEPTH(FIFO_DEPTH)) u_txq (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.in_data(reg_wdata),
		.in_valid(wr_data),
		.in_ready(tx_ready),
		.out_data(q_data),
		.out_valid(q_valid),
		.out_ready(q_take)
	);

	assign q_take = (tx_state == ASGEN_TX_IDLE) && mode.tx_enable && q_valid;
	assign tx_bit_end = fsck_tick && (tx_cnt == half_lim) && tx_phase;

	// RL25: bit time is two half periods of the divided source
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_cnt <= 5'h00;
			tx_phase <= 1'b0;
		end else if (tx_state == ASGEN_TX_IDLE) begin
			tx_cnt <= 5'h00;
			tx_phase <= 1'b0;
		end else if (fsck_tick) begin
			if (tx_cnt == half_lim) begin
				tx_cnt <= 5'h00;
				tx_phase <= ~tx_phase;
			end else begin
				tx_cnt <= tx_cnt + 5'h01;
			end
		end
	end

	// Transmit sequencer; clearing tx enable abandons the frame
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_state <= ASGEN_TX_IDLE;
			tx_shift_reg <= ASGEN_TX_IDLE_CHAR;
			tx_bits <= 3'h0;
			tx_par <= 1'b0;
			tx_stop2 <= 1'b0;
			txd <= 1'b1;
			tx_done_irq <= 1'b0;
		end else begin
			tx_done_irq <= 1'b0;
			if (!mode.tx_enable) begin
				// RL26: line idles high
				tx_state <= ASGEN_TX_IDLE;
				txd <= 1'b1;
			end else begin
				case (tx_state)
					ASGEN_TX_IDLE: begin
						txd <= 1'b1;
						if (q_valid) begin
							// RL24: bit seven dropped for short characters
							tx_shift_reg <= mode.char8 ? q_data : {1'b0, q_data[6:0]};
							// RL23: parity from chosen scheme
							tx_par <= par_bit(mode.parity,
								mode.char8 ? q_data : {1'b0, q_data[6:0]});
							tx_stop2 <= mode.stop2;
							tx_bits <= 3'h0;
							// RL1: start bit added
							txd <= 1'b0;
							tx_state <= ASGEN_TX_START;
						end
					end
					ASGEN_TX_START: begin
						if (tx_bit_end) begin
							txd <= tx_shift_reg[0];
							tx_state <= ASGEN_TX_DATA;
						end
					end
					ASGEN_TX_DATA: begin
						if (tx_bit_end) begin
							tx_shift_reg <= {1'b1, tx_shift_reg[7:1]};
							tx_bits <= tx_bits + 3'h1;
							if (tx_bits == (mode.char8 ? 3'h7 : 3'h6)) begin
								if (mode.parity == ASGEN_PAR_NONE) begin
									txd <= 1'b1;
									tx_state <= ASGEN_TX_STOP;
								end else begin
									txd <= tx_par;
									tx_state <= ASGEN_TX_PARITY;
								end
							end else begin
								txd <= tx_shift_reg[1];
							end
						end
					end
					ASGEN_TX_PARITY: begin
						if (tx_bit_end) begin
							txd <= 1'b1;
							tx_state <= ASGEN_TX_STOP;
						end
					end
					ASGEN_TX_STOP: begin
						if (tx_bit_end) begin
							if (tx_stop2) begin
								tx_stop2 <= 1'b0;
							end else begin
								// RL2: shift register empty, signal done
								tx_done_irq <= 1'b1;
								tx_state <= ASGEN_TX_IDLE;
							end
						end
					end
					default: begin
						tx_state <= ASGEN_TX_IDLE;
					end
				endcase
			end
		end
	end

	// RL2: sticky done flag, a new frame done wins over the write clear
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_done_flag <= 1'b0;
		end else if (tx_done_irq) begin
			tx_done_flag <= 1'b1;
		end else if (wr_data) begin
			tx_done_flag <= 1'b0;
		end
	end

	// ****************************************
	// Receiver
	// ****************************************
	asgen_rx_state_t rx_state;
	logic [7:0] rx_shift;      // Incoming bits, LSB first
	logic [2:0] rx_bits;       // Data bits taken
	logic rx_par_got;          // Received parity bit
	logic [4:0] rx_cnt;        // 5-bit bit timer
	logic rx_phase;            // Second half of a bit
	logic rx_half;             // Half bit elapsed
	logic rx_sample;           // Mid-bit sample point
	logic rx_unread;           // Buffer holds unread data
	logic rx_done_pend;        // Done request waiting for its slot
	logic [7:0] rx_char;       // Assembled character
	asgen_status_t rx_errs;    // Errors of the frame in hand

	assign rx_half = fsck_tick && (rx_cnt == half_lim);
	assign rx_sample = rx_half && rx_phase;
	// RL24: bit seven reads zero for short characters
	assign rx_char = mode.char8 ? rx_shift : {1'b0, rx_shift[7:1]};

	// RL13: parity, framing and overrun causes
	always_comb begin
		rx_errs = '0;
		rx_errs.parity_err = (mode.parity == ASGEN_PAR_EVEN || mode.parity == ASGEN_PAR_ODD)
			&& (par_bit(mode.parity, rx_char) != rx_par_got);
		rx_errs.framing_err = !rx_level;
		rx_errs.overrun_err = rx_unread && !rd_data;
	end

	// RL5: counter restarts at the edge and again on a confirmed start bit
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_cnt <= 5'h00;
			rx_phase <= 1'b0;
		end else if (rx_state == ASGEN_RX_IDLE || (rx_state == ASGEN_RX_START && rx_half)) begin
			rx_cnt <= 5'h00;
			rx_phase <= 1'b0;
		end else if (fsck_tick) begin
			if (rx_cnt == half_lim) begin
				rx_cnt <= 5'h00;
				rx_phase <= ~rx_phase;
			end else begin
				rx_cnt <= rx_cnt + 5'h01;
			end
		end
	end

	// Receive sequencer, buffer, status and requests
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_state <= ASGEN_RX_IDLE;
			rx_shift <= 8'h00;
			rx_bits <= 3'h0;
			rx_par_got <= 1'b0;
			rx_buffer_reg <= 8'h00;
			status <= '0;
			rx_unread <= 1'b0;
			rx_done_pend <= 1'b0;
			rx_done_irq <= 1'b0;
			rx_error_irq <= 1'b0;
		end else begin
			rx_done_irq <= 1'b0;
			rx_error_irq <= 1'b0;
			// RL14: a buffer read clears status and unread mark
			if (rd_data) begin
				status <= '0;
				rx_unread <= 1'b0;
			end
			if (!mode.rx_enable) begin
				// RL9: stop at once, nothing updated or requested
				// RL10: a pending done request is dropped too
				rx_state <= ASGEN_RX_IDLE;
				rx_done_pend <= 1'b0;
			end else begin
				// RL10: done request issues one source tick after loading
				if (rx_done_pend && fsck_tick) begin
					rx_done_pend <= 1'b0;
					rx_done_irq <= 1'b1;
				end
				case (rx_state)
					ASGEN_RX_IDLE: begin
						// RL4: sampling only while enabled
						if (!rx_level) begin
							rx_state <= ASGEN_RX_START;
						end
					end
					ASGEN_RX_START: begin
						// RL5: recheck after half a bit
						if (rx_half) begin
							rx_bits <= 3'h0;
							rx_state <= rx_level ? ASGEN_RX_IDLE : ASGEN_RX_DATA;
						end
					end
					ASGEN_RX_DATA: begin
						if (rx_sample) begin
							rx_shift <= {rx_level, rx_shift[7:1]};
							rx_bits <= rx_bits + 3'h1;
							if (rx_bits == (mode.char8 ? 3'h7 : 3'h6)) begin
								rx_state <= (mode.parity == ASGEN_PAR_NONE) ? ASGEN_RX_STOP
									: ASGEN_RX_PARITY;
							end
						end
					end
					ASGEN_RX_PARITY: begin
						if (rx_sample) begin
							rx_par_got <= rx_level;
							rx_state <= ASGEN_RX_STOP;
						end
					end
					ASGEN_RX_STOP: begin
						// RL6: one stop bit closes the frame
						if (rx_sample) begin
							// RL7: load buffer even for errored frames
							rx_buffer_reg <= rx_char;
							rx_unread <= 1'b1;
							// RL14: next frame replaces status, winning over a read
							status <= rx_errs;
							// RL12: error request goes out first
							rx_error_irq <= (rx_errs != '0);
							// RL8: suppress done on error when asked
							rx_done_pend <= (rx_errs == '0) || !mode.err_suppress_done;
							rx_state <= ASGEN_RX_IDLE;
						end
					end
					default: begin
						rx_state <= ASGEN_RX_IDLE;
					end
				endcase
			end
		end
	end

	// ****************************************
	// Synchronous mode pins
	// ****************************************
	// RL17: three lines; shift timing lives elsewhere, so clock idles high and out is high, or echoes in while bit 7 is set
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_serial_clk <= 1'b1;
			sync_serial_out <= 1'b1;
		end else begin
			sync_serial_clk <= 1'b1;
			sync_serial_out <= sync_mode[7] ? si_level : 1'b1;
		end
	end

endmodule

/* File: hw/asgen_pkg.sv */
// Shared constants, register layouts and state types for the async serial port
package asgen_pkg;

	// ****************************************
	// Register addresses
	// ****************************************
	localparam logic [15:0] ASGEN_ADDR_MODE = 16'hff70;   // Async mode register
	localparam logic [15:0] ASGEN_ADDR_STATUS = 16'hff71; // Receive status register
	localparam logic [15:0] ASGEN_ADDR_SYNC = 16'hff72;   // Synchronous mode register
	localparam logic [15:0] ASGEN_ADDR_BAUD = 16'hff73;   // Baud control register
	localparam logic [15:0] ASGEN_ADDR_DATA = 16'hff74;   // Read rx buffer, write tx queue

	// ****************************************
	// Reset values and masks
	// ****************************************
	localparam logic [7:0] ASGEN_MODE_RST = 8'h00;
	localparam logic [7:0] ASGEN_SYNC_RST = 8'h00;
	localparam logic [7:0] ASGEN_BAUD_RST = 8'h00;
	localparam logic [7:0] ASGEN_SYNC_WMASK = 8'h86; // Bits 0 and 3..6 held at zero
	localparam logic [7:0] ASGEN_TX_IDLE_CHAR = 8'hff; // Value the tx shift register loads at reset

	// ****************************************
	// Parity selections
	// ****************************************
	localparam logic [1:0] ASGEN_PAR_NONE = 2'h0;
	localparam logic [1:0] ASGEN_PAR_ZERO = 2'h1;
	localparam logic [1:0] ASGEN_PAR_ODD = 2'h2;
	localparam logic [1:0] ASGEN_PAR_EVEN = 2'h3;

	// ****************************************
	// Baud generator codes
	// ****************************************
	localparam logic [3:0] ASGEN_PRE_SLOW = 4'h0;   // Source is system clock / 2^10
	localparam logic [3:0] ASGEN_PRE_BASE = 4'h5;   // Source is system clock / 2^0
	localparam logic [3:0] ASGEN_PRE_TOP = 4'he;    // Source is system clock / 2^9
	localparam int ASGEN_PRE_SLOW_SHIFT = 10;       // Exponent of the slowest source
	localparam logic [3:0] ASGEN_DIV_BYPASS = 4'hf; // Divider passes source undivided
	localparam logic [4:0] ASGEN_DIV_BASE = 5'h10;  // Divider is 16 plus k
	localparam int ASGEN_FIFO_DEPTH = 4;            // Words queued for transmit
	localparam int ASGEN_DATA_W = 8;                // Character width

	// ****************************************
	// Register layouts
	// ****************************************
	typedef struct packed {
		logic tx_enable;          // Bit 7
		logic rx_enable;          // Bit 6
		logic [1:0] parity;       // Bits 5..4
		logic char8;              // Bit 3, 1 gives 8 character bits
		logic stop2;              // Bit 2, 1 gives two stop bits
		logic err_suppress_done;  // Bit 1
		logic clk_sel;            // Bit 0, stored only
	} asgen_mode_t;

	typedef struct packed {
		logic [4:0] rsvd;         // Read as zero
		logic parity_err;         // Bit 2
		logic framing_err;        // Bit 1
		logic overrun_err;        // Bit 0
	} asgen_status_t;

	typedef struct packed {
		logic [3:0] prescale_select;
		logic [3:0] divider_select;
	} asgen_baud_t;

	// ****************************************
	// State types
	// ****************************************
	typedef enum logic [2:0] {ASGEN_TX_IDLE, ASGEN_TX_START, ASGEN_TX_DATA, ASGEN_TX_PARITY,
		ASGEN_TX_STOP} asgen_tx_state_t;
	typedef enum logic [2:0] {ASGEN_RX_IDLE, ASGEN_RX_START, ASGEN_RX_DATA, ASGEN_RX_PARITY,
		ASGEN_RX_STOP} asgen_rx_state_t;

endpackage

/* File: hw/asgen_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module asgen_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);
	localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];  // Storage words
	logic [PW-1:0] wr_ptr;          // Next slot to fill
	logic [PW-1:0] rd_ptr;          // Oldest slot
	logic [PW:0] count;             // Words held
	logic push;
	logic pop;

	assign in_ready = (count != FULL_COUNT);
	assign out_valid = (count != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Storage write, no reset needed on data
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Head word comes from a register, refreshed after each move
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_data <= '0;
		end else if (pop) begin
			out_data <= (count > (PW+1)'(1)) ? mem[(rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1]
				: in_data;
		end else if (!out_valid || (count == (PW+1)'(1) && push && pop)) begin
			out_data <= in_data;
		end
	end

	// Pointers and fill level
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule

/* File: tb/asgen_uart_props.sv */
// Port-level checks for the async serial port
`timescale 1ns/10ps
module asgen_uart_props
	import asgen_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic tx_ready,
	input wire logic txd,
	input wire logic tx_done_irq,
	input wire logic tx_done_flag,
	input wire logic rx_done_irq,
	input wire logic rx_error_irq
);
	logic [7:0] mode_q; // Mode shadow
	logic [7:0] baud_q; // Baud shadow
	// Shadow writes
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_q <= 8'h00;
			baud_q <= 8'h00;
		end else if (reg_wr && reg_addr == ASGEN_ADDR_MODE) begin
			mode_q <= reg_wdata;
		end else if (reg_wr && reg_addr == ASGEN_ADDR_BAUD) begin
			baud_q <= reg_wdata;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	sequence s_buf_rd;
		reg_rd && reg_addr == ASGEN_ADDR_DATA && !rx_error_irq;
	endsequence
	sequence s_stat_rd;
		reg_rd && reg_addr == ASGEN_ADDR_STATUS && !rx_error_irq;
	endsequence
	AST_TX_START: assert property (reg_wr && reg_addr == ASGEN_ADDR_DATA
		&& tx_ready && mode_q[7] |-> ##[1:300] !txd) else $error("no start bit");
	AST_TX_FLAG: assert property (tx_done_irq |=> tx_done_flag)
		else $error("done flag not set");
	AST_TX_IDLE: assert property (tx_done_irq |-> txd) else $error("line low at end");
	AST_RX_EN_DONE: assert property (rx_done_irq |-> $past(mode_q[6]))
		else $error("done while disabled");
	AST_RX_EN_ERR: assert property (rx_error_irq |-> $past(mode_q[6]))
		else $error("error while disabled");
	AST_ERR_FIRST: assert property (rx_error_irq && !mode_q[1]
		|-> !rx_done_irq ##[1:1000] rx_done_irq) else $error("error not before done");
	AST_SUPPRESS: assert property (rx_error_irq && mode_q[1] |=> !rx_done_irq [*4])
		else $error("done not suppressed");
	AST_BAUD_RD: assert property (reg_rd && reg_addr == ASGEN_ADDR_BAUD
		|=> reg_rdata == baud_q) else $error("baud readback");
	AST_SYNC_ZERO: assert property (reg_rd && reg_addr == ASGEN_ADDR_SYNC
		|=> (reg_rdata & 8'h79) == 8'h00) else $error("sync reserved bits set");
	AST_STATUS_CLR: assert property (s_buf_rd ##1 !rx_error_irq ##1 s_stat_rd
		|=> reg_rdata == 8'h00) else $error("status not cleared");
endmodule
bind asgen_uart asgen_uart_props asgen_uart_props_i (.sys_clk, .arst_n, .reg_addr, .reg_wr,
	.reg_rd, .reg_wdata, .reg_rdata, .tx_ready, .txd, .tx_done_irq, .tx_done_flag,
	.rx_done_irq, .rx_error_irq);

/* File: tb/asgen_peer.sv */
// Remote serial transceiver model on the line pair
`timescale 1ns/10ps
module asgen_peer (
	input wire logic sys_clk,
	input wire logic txd,
	output logic rxd
);
	int bit_cyc = 2; // Cycles per bit, set by the bench
	initial rxd = 1'b1;
	// start bit, then bits LSB first
	task automatic send(input logic [11:0] b, input int n);
		@(posedge sys_clk);
		#1 rxd = 1'b0;
		for (int i = 0; i < n; i++) begin
			repeat (bit_cyc) @(posedge sys_clk);
			#1 rxd = b[i];
		end
		repeat (bit_cyc) @(posedge sys_clk);
		#1 rxd = 1'b1;
	endtask
	// Find start bit, sample each bit
	task automatic catch(input int n, output logic [11:0] b);
		int w;
		b = 12'h000;
		w = 0;
		do begin
			@(posedge sys_clk);
			#1 w++;
		end while (txd !== 1'b0 && w < 400);
		for (int i = 0; i < n; i++) begin
			repeat (bit_cyc) @(posedge sys_clk);
			#1 b[i] = txd;
		end
	endtask
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the async serial port
`timescale 1ns/10ps
module testbench;
	import asgen_pkg::*;
	logic sys_clk, arst_n, reg_wr, reg_rd, tx_ready, txd, rxd;
	logic sync_serial_clk, sync_serial_out, tx_done_irq, tx_done_flag;
	logic rx_done_irq, rx_error_irq;
	logic [15:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic [11:0] bits;
	int mismatches = 0;
	int cmp_count = 0;
	int n_done = 0;
	int n_err = 0;
	asgen_uart asgen_uart_i (.sys_clk, .arst_n, .osc_mode_bit(1'b1), .reg_addr, .reg_wr,
		.reg_rd, .reg_wdata, .reg_rdata, .tx_ready, .rxd, .txd, .sync_serial_clk,
		.sync_serial_out, .sync_serial_in(1'b1), .tx_done_irq, .tx_done_flag, .rx_done_irq,
		.rx_error_irq);
	asgen_peer asgen_peer_i (.sys_clk, .txd, .rxd);
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Count receive pulses
	always @(posedge sys_clk) begin
		if (rx_done_irq === 1'b1) n_done++;
		if (rx_error_irq === 1'b1) n_err++;
	end
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		#1 reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge sys_clk);
		#1 reg_wr = 1'b0;
	endtask
	task automatic rc(input logic [15:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		#1 reg_rd = 1'b1;
		reg_addr = a;
		@(posedge sys_clk);
		#1 reg_rd = 1'b0;
		chk({4'h0, reg_rdata}, {4'h0, e});
	endtask
	// Peer frame, optional abort, pulse counts
	task automatic rx(input logic [11:0] b, input int n, input bit ab, input int ed,
		input int ee);
		int d0;
		int e0;
		d0 = n_done;
		e0 = n_err;
		fork
			asgen_peer_i.send(b, n);
			if (ab) begin
				repeat (8) @(posedge sys_clk);
				wr(ASGEN_ADDR_MODE, 8'h00);
			end
		join
		repeat (8) @(posedge sys_clk);
		chk(12'(n_done - d0), 12'(ed));
		chk(12'(n_err - e0), 12'(ee));
	endtask
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#300000;
		mismatches++;
		final_report();
	end
	initial begin
		{arst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		repeat (10) @(posedge sys_clk);
		#1 arst_n = 1'b1;
		repeat (3) @(posedge sys_clk);
		rc(ASGEN_ADDR_MODE, 8'h00);
		rc(ASGEN_ADDR_SYNC, 8'h00);
		rc(ASGEN_ADDR_BAUD, 8'h00);
		rc(16'hff7f, 8'h00);
		wr(ASGEN_ADDR_SYNC, 8'hff);
		rc(ASGEN_ADDR_SYNC, ASGEN_SYNC_WMASK);
		chk({10'h0, sync_serial_clk, sync_serial_out}, 12'h003);
		wr(ASGEN_ADDR_SYNC, 8'h00);
		wr(ASGEN_ADDR_BAUD, 8'h5f);
		rc(ASGEN_ADDR_BAUD, 8'h5f);
		$display("Test registers done");
		wr(ASGEN_ADDR_MODE, 8'hb8);
		wr(ASGEN_ADDR_DATA, 8'ha5);
		asgen_peer_i.catch(10, bits);
		chk(bits, 12'h2a5);
		repeat (4) @(posedge sys_clk);
		chk({11'h0, tx_done_flag}, 12'h001);
		wr(ASGEN_ADDR_MODE, 8'ha0);
		wr(ASGEN_ADDR_DATA, 8'hff);
		asgen_peer_i.catch(9, bits);
		chk(bits, 12'h17f);
		wr(ASGEN_ADDR_BAUD, 8'h6f);
		asgen_peer_i.bit_cyc = 4;
		wr(ASGEN_ADDR_MODE, 8'h88);
		wr(ASGEN_ADDR_DATA, 8'h5a);
		asgen_peer_i.catch(9, bits);
		chk(bits, 12'h15a);
		repeat (8) @(posedge sys_clk);
		wr(ASGEN_ADDR_BAUD, 8'h5f);
		asgen_peer_i.bit_cyc = 2;
		wr(ASGEN_ADDR_MODE, 8'h08);
		for (int i = 0; i < 5; i++) wr(ASGEN_ADDR_DATA, 8'h10 + 8'(i));
		chk({11'h0, tx_ready}, 12'h000);
		wr(ASGEN_ADDR_MODE, 8'h88);
		for (int i = 0; i < 4; i++) begin
			asgen_peer_i.catch(9, bits);
			chk(bits, 12'h110 + 12'(i));
		end
		$display("Test transmit done");
		wr(ASGEN_ADDR_MODE, 8'h78);
		rx(12'h23c, 10, 0, 1, 0);
		rc(ASGEN_ADDR_STATUS, 8'h00);
		rc(ASGEN_ADDR_DATA, 8'h3c);
		rx(12'h201, 10, 0, 1, 1);
		rc(ASGEN_ADDR_STATUS, 8'h04);
		rc(ASGEN_ADDR_DATA, 8'h01);
		rc(ASGEN_ADDR_STATUS, 8'h00);
		rx(12'h255, 10, 0, 1, 0);
		rx(12'h255, 10, 0, 1, 1);
		rc(ASGEN_ADDR_STATUS, 8'h01);
		rx(12'h00f, 10, 0, 1, 1);
		rc(ASGEN_ADDR_STATUS, 8'h03);
		rc(ASGEN_ADDR_DATA, 8'h0f);
		wr(ASGEN_ADDR_MODE, 8'h7a);
		rx(12'h201, 10, 0, 0, 1);
		rc(ASGEN_ADDR_DATA, 8'h01);
		wr(ASGEN_ADDR_MODE, 8'h40);
		rx(12'h0ff, 8, 0, 1, 0);
		rc(ASGEN_ADDR_DATA, 8'h7f);
		wr(ASGEN_ADDR_MODE, 8'h78);
		rx(12'h2aa, 10, 1, 0, 0);
		rc(ASGEN_ADDR_STATUS, 8'h00);
		rc(ASGEN_ADDR_DATA, 8'h7f);
		$display("Test receive done");
		final_report();
	end
endmodule
